// ==== inc/tsq_pkg.sv ====
/*
 * Shared constants of the trigger and status sequencer: command codes,
 * trigger source codes, condition word bit positions, reset values and
 * the millisecond timing figures.
 * Assumes a single 20 MHz system clock.
 */
package tsq_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int CMD_W = 4;
	localparam int ARG_W = 17;
	localparam int CNT_W = 16;
	localparam int SRC_W = 5;
	localparam int SRC_N = 23;
	localparam int OPC_W = 16;
	localparam int TPAT_W = 16;
	localparam int TSTEP_W = 5;

	// ****************************************************************
	// Host command codes
	// ****************************************************************
	localparam logic [CMD_W-1:0] CMD_SET_COUNT = 4'h1;
	localparam logic [CMD_W-1:0] CMD_SET_DELAY = 4'h2;
	localparam logic [CMD_W-1:0] CMD_SET_TALLY = 4'h3;
	localparam logic [CMD_W-1:0] CMD_SET_SOURCE = 4'h4;
	localparam logic [CMD_W-1:0] CMD_TRIG_IMM = 4'h5;
	localparam logic [CMD_W-1:0] CMD_INITIATE = 4'h6;
	localparam logic [CMD_W-1:0] CMD_ABORT = 4'h7;
	localparam logic [CMD_W-1:0] CMD_SELF_TEST = 4'h8;

	// ****************************************************************
	// Trigger source codes (index into the trigger line vector)
	// ****************************************************************
	localparam logic [SRC_W-1:0] SRC_HOLD = 5'h00;
	localparam logic [SRC_W-1:0] SRC_IMMEDIATE = 5'h01;
	localparam logic [SRC_W-1:0] SRC_BUS = 5'h02;
	localparam logic [SRC_W-1:0] SRC_TTL0 = 5'h03;
	localparam logic [SRC_W-1:0] SRC_CMD0 = 5'h0B;
	localparam logic [SRC_W-1:0] SRC_TIMER = 5'h10;
	localparam logic [SRC_W-1:0] SRC_LAST = 5'h16;

	// ****************************************************************
	// Condition word bit positions
	// ****************************************************************
	localparam int OPC_SETTLING = 1;
	localparam int OPC_SWEEPING = 3;
	localparam int OPC_WAIT_ARM = 5;
	localparam int OPC_TESTING = 8;
	localparam int OPC_ABORTING = 9;

	// ****************************************************************
	// Limits and reset values
	// ****************************************************************
	localparam logic [CNT_W-1:0] RST_COUNT = 16'h0001;
	localparam logic [ARG_W-1:0] RST_DELAY = 17'h00000;
	localparam logic [ARG_W-1:0] RST_TALLY = 17'h00000;
	localparam logic [SRC_W-1:0] RST_SOURCE = SRC_IMMEDIATE;
	localparam logic [OPC_W-1:0] RST_OPC = 16'h0000;
	localparam logic [ARG_W-1:0] ARG_MAX = 17'h10000;
	localparam logic [CNT_W-1:0] COUNT_MIN = 16'h0001;
	localparam logic [3:0] ABORT_CYCLES = 4'h4;
	localparam logic [TSTEP_W-1:0] TEST_STEPS = 5'h12;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

endpackage

// ==== inc/tsq_link_if.sv ====
/*
 * Internal carrier between the sequencer core, its trigger qualifier
 * and its self-test engine.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/10ps
interface tsq_link_if;
	import tsq_pkg::*;

	// Qualifier group
	logic q_arm;
	logic q_trig;
	logic q_bypass;
	logic [ARG_W-1:0] q_delay;
	logic [ARG_W-1:0] q_tally;
	logic q_fire;
	// Self-test group
	logic t_start;
	logic t_busy;
	logic t_done;
	logic t_pass;

	modport ctl (output q_arm, q_trig, q_bypass, q_delay, q_tally,
		t_start, input q_fire, t_busy, t_done, t_pass);
	modport qual (input q_arm, q_trig, q_bypass, q_delay, q_tally,
		output q_fire);
	modport test (input t_start, output t_busy, t_done, t_pass);
endinterface

// ==== design/tsq_qualifier.sv ====
/*
 * Trigger qualifier: passes, delays by whole milliseconds, or counts
 * triggers before firing.
 * Assumes triggers are one-cycle pulses synchronous to clk.
 */
`timescale 1ns/10ps
module tsq_qualifier #(
	parameter int MS_CYC = tsq_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	tsq_link_if.qual lnk
);
	import tsq_pkg::*;

	logic [31:0] tick_ff;
	logic [ARG_W-1:0] left_ff;
	logic pend_ff;
	logic fire_ff;
	logic ms_tick;

	assign lnk.q_fire = fire_ff;
	assign ms_tick = (tick_ff == 32'(MS_CYC - 1));

	// Delay or event count in flight; dropped when disarmed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_ff <= 1'b0;
			left_ff <= '0;
			tick_ff <= '0;
			fire_ff <= 1'b0;
		end else begin
			fire_ff <= 1'b0;
			if (!lnk.q_arm) begin
				pend_ff <= 1'b0;
			end else if (!pend_ff && lnk.q_trig) begin
				if (lnk.q_bypass || (lnk.q_delay == '0 &&
					lnk.q_tally == '0)) begin
					fire_ff <= 1'b1;
				end else if (lnk.q_tally == ARG_W'(1)) begin
					fire_ff <= 1'b1;
				end else begin
					pend_ff <= 1'b1;
					tick_ff <= '0;
					left_ff <= (lnk.q_tally != '0) ?
						lnk.q_tally - ARG_W'(1) : lnk.q_delay;
				end
			end else if (pend_ff && lnk.q_tally != '0) begin
				if (lnk.q_trig) begin
					left_ff <= left_ff - ARG_W'(1);
					if (left_ff == ARG_W'(1)) begin
						pend_ff <= 1'b0;
						fire_ff <= 1'b1;
					end
				end
			end else if (pend_ff) begin
				tick_ff <= ms_tick ? '0 : tick_ff + 32'd1;
				if (ms_tick) begin
					left_ff <= left_ff - ARG_W'(1);
					if (left_ff == ARG_W'(1)) begin
						pend_ff <= 1'b0;
						fire_ff <= 1'b1;
					end
				end
			end
		end
	end

endmodule // tsq_qualifier

// ==== design/tsq_self_test.sv ====
/*
 * Self-test engine: walks patterns through the scanner data path and
 * checks the loopback, keeping the first failing step and data.
 * Assumes the loopback answers one cycle after a pattern is driven.
 */
`timescale 1ns/10ps
module tsq_self_test (
	input wire logic clk,
	input wire logic rst,
	tsq_link_if.test lnk,
	input wire logic [tsq_pkg::TPAT_W-1:0] loop_in,
	output logic [tsq_pkg::TPAT_W-1:0] pat_ff,
	output logic [tsq_pkg::TSTEP_W-1:0] fail_step_ff,
	output logic [tsq_pkg::TPAT_W-1:0] fail_data_ff
);
	import tsq_pkg::*;

	logic [TSTEP_W-1:0] step_ff;
	logic phase_ff;
	logic busy_ff;
	logic done_ff;
	logic pass_ff;
	logic [TPAT_W-1:0] nxt_pat;

	assign lnk.t_busy = busy_ff;
	assign lnk.t_done = done_ff;
	assign lnk.t_pass = pass_ff;

	// Walking one, then all zeros, then all ones
	always_comb begin
		if (step_ff < TSTEP_W'(TPAT_W))
			nxt_pat = TPAT_W'(1) << step_ff;
		else if (step_ff == TSTEP_W'(TPAT_W))
			nxt_pat = '0;
		else
			nxt_pat = '1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			pass_ff <= 1'b0;
			step_ff <= '0;
			phase_ff <= 1'b0;
			pat_ff <= '0;
			fail_step_ff <= '0;
			fail_data_ff <= '0;
		end else begin
			done_ff <= 1'b0;
			if (lnk.t_start && !busy_ff) begin
				busy_ff <= 1'b1;
				pass_ff <= 1'b1;
				step_ff <= '0;
				phase_ff <= 1'b0;
				fail_step_ff <= '0;
				fail_data_ff <= '0;
			end else if (busy_ff && !phase_ff) begin
				pat_ff <= nxt_pat;
				phase_ff <= 1'b1;
			end else if (busy_ff) begin
				phase_ff <= 1'b0;
				if (loop_in != pat_ff && pass_ff) begin
					pass_ff <= 1'b0;
					fail_step_ff <= step_ff;
					fail_data_ff <= loop_in;
				end
				step_ff <= step_ff + TSTEP_W'(1);
				if (step_ff == TEST_STEPS - TSTEP_W'(1)) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end

endmodule // tsq_self_test

// ==== design/tsq_sequencer.sv ====
/*
 * Trigger sequencer and operation condition word of a relay scanner
 * controller. Holds the trigger settings, runs the initiate / wait /
 * sweep / abort sequence and drives the self-test engine.
 * Assumes host commands and all trigger and scan inputs are one-cycle
 * pulses synchronous to clk.
 */
// Contract
// - Bit 1 set on function or range change, cleared once settled.
// - Bit 3 set at scan start, cleared at list end or abort.
// - Bit 5 high while waiting for arm, cleared on arm.
// - Bit 8 high while self-test runs.
// - Bit 9 high while abort in progress, cleared when done.
// - Master selected: condition word reads all zero.
// - Delay is zero pass-through or 1 to 65536 ms in 1 ms steps.
// - Source: bus, eight TTL lines, five command lines, internal events.
// - Self-test exercises control logic and data path of selected module; the engine here only walks patterns through the data path loopback.
// - Self-test result reported as single pass or fail.
// - Failure details kept for later error query.
// - Trigger settings decide when each scan step begins.
// - Wait, decrement per trigger, re-wait until zero, then idle.
// - Writing delay clears the event count.
// - Writing event count clears delay; fire on Nth trigger.
// - Immediate command triggers once, ignoring the source.
`timescale 1ns/10ps
module tsq_sequencer #(
	parameter int MS_CYC = tsq_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [tsq_pkg::CMD_W-1:0] cmd_code,
	input wire logic [tsq_pkg::ARG_W-1:0] cmd_arg,
	input wire logic [tsq_pkg::SRC_N-1:0] trig_lines,
	input wire logic func_change,
	input wire logic settle_done,
	input wire logic list_end,
	input wire logic master_sel,
	input wire logic [tsq_pkg::TPAT_W-1:0] test_loop_in,
	output logic [tsq_pkg::OPC_W-1:0] opcond_ff,
	output logic step_begin_ff,
	output logic [tsq_pkg::CNT_W-1:0] count_set_ff,
	output logic [tsq_pkg::ARG_W-1:0] delay_set_ff,
	output logic [tsq_pkg::ARG_W-1:0] trigger_event_tally_ff,
	output logic [tsq_pkg::SRC_W-1:0] source_set_ff,
	output logic [tsq_pkg::CNT_W-1:0] count_left_ff,
	output logic test_done_ff,
	output logic test_pass_ff,
	output logic [tsq_pkg::TPAT_W-1:0] test_pat_ff,
	output logic [tsq_pkg::TSTEP_W-1:0] test_fail_step_ff,
	output logic [tsq_pkg::TPAT_W-1:0] test_fail_data_ff
);
	import tsq_pkg::*;

	typedef enum logic [1:0] {
		TSQ_IDLE,
		TSQ_WAIT,
		TSQ_SWEEP,
		TSQ_ABORT
	} tsq_state_t;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	tsq_state_t state_ff;
	tsq_state_t nxt_state;
	logic [3:0] abort_cnt_ff;
	logic settling_ff;
	logic fire_ff;
	logic imm_ff;
	logic [OPC_W-1:0] nxt_opcond;
	logic cmd_set_count;
	logic cmd_set_delay;
	logic cmd_set_tally;
	logic cmd_set_source;
	logic cmd_imm;
	logic cmd_init;
	logic cmd_abort;
	logic cmd_test;
	logic raw_trig;
	logic fixed_src;
	logic arm_now;
	logic [ARG_W-1:0] arg_clip;

	tsq_link_if lnk ();

	// ****************************************************************
	// Command decode
	// ****************************************************************

	// One strobe per command kind
	assign cmd_set_count = cmd_valid && cmd_code == CMD_SET_COUNT;
	assign cmd_set_delay = cmd_valid && cmd_code == CMD_SET_DELAY;
	assign cmd_set_tally = cmd_valid && cmd_code == CMD_SET_TALLY;
	assign cmd_set_source = cmd_valid && cmd_code == CMD_SET_SOURCE;
	assign cmd_imm = cmd_valid && cmd_code == CMD_TRIG_IMM;
	assign cmd_init = cmd_valid && cmd_code == CMD_INITIATE;
	assign cmd_abort = cmd_valid && cmd_code == CMD_ABORT;
	assign cmd_test = cmd_valid && cmd_code == CMD_SELF_TEST;

	// Out-of-range delay or tally saturates rather than wrapping
	assign arg_clip = (cmd_arg > ARG_MAX) ? ARG_MAX : cmd_arg;

	// ****************************************************************
	// Trigger settings
	// ****************************************************************

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_set_ff <= RST_COUNT;
			delay_set_ff <= RST_DELAY;
			trigger_event_tally_ff <= RST_TALLY;
			source_set_ff <= RST_SOURCE;
		end else begin
			if (cmd_set_count) begin
				if (cmd_arg[CNT_W-1:0] == '0 || cmd_arg[ARG_W-1])
					count_set_ff <= cmd_arg[ARG_W-1] ? '1 : COUNT_MIN;
				else
					count_set_ff <= cmd_arg[CNT_W-1:0];
			end
			if (cmd_set_delay) begin
				delay_set_ff <= arg_clip;
				trigger_event_tally_ff <= '0;
			end
			if (cmd_set_tally) begin
				trigger_event_tally_ff <= arg_clip;
				delay_set_ff <= '0;
			end
			if (cmd_set_source && cmd_arg <= ARG_W'(SRC_LAST))
				source_set_ff <= cmd_arg[SRC_W-1:0];
		end
	end

	// ****************************************************************
	// Trigger source selection
	// ****************************************************************

	// Pick the selected line; hold never fires, immediate always
	always_comb begin
		if (source_set_ff == SRC_HOLD)
			raw_trig = 1'b0;
		else if (source_set_ff == SRC_IMMEDIATE)
			raw_trig = 1'b1;
		else
			raw_trig = trig_lines[source_set_ff];
	end

	// Fixed sources ignore delay and tally
	assign fixed_src = source_set_ff == SRC_HOLD ||
		source_set_ff == SRC_IMMEDIATE || source_set_ff == SRC_TIMER;

	// Qualifier armed only in the waiting state
	assign lnk.q_arm = state_ff == TSQ_WAIT && !imm_ff && !fire_ff;
	assign lnk.q_trig = raw_trig;
	assign lnk.q_bypass = fixed_src;
	assign lnk.q_delay = delay_set_ff;
	assign lnk.q_tally = trigger_event_tally_ff;
	assign lnk.t_start = cmd_test && state_ff == TSQ_IDLE;

	tsq_qualifier #(
		.MS_CYC(MS_CYC)
	) u_qual (
		.clk(clk),
		.rst(rst),
		.lnk(lnk.qual)
	);

	tsq_self_test u_test (
		.clk(clk),
		.rst(rst),
		.lnk(lnk.test),
		.loop_in(test_loop_in),
		.pat_ff(test_pat_ff),
		.fail_step_ff(test_fail_step_ff),
		.fail_data_ff(test_fail_data_ff)
	);

	// ****************************************************************
	// Arm capture
	// ****************************************************************

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			imm_ff <= 1'b0;
			fire_ff <= 1'b0;
		end else begin
			imm_ff <= cmd_imm && state_ff == TSQ_WAIT && !fire_ff &&
				!cmd_abort;
			fire_ff <= lnk.q_fire && state_ff == TSQ_WAIT && !cmd_abort;
		end
	end

	// Arm arrives from the qualifier or from the immediate command
	assign arm_now = fire_ff || imm_ff;

	// ****************************************************************
	// Sequence state machine
	// ****************************************************************

	// Wait, sweep, re-wait until count spent
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			TSQ_IDLE: begin
				if (cmd_init && !lnk.t_busy)
					nxt_state = TSQ_WAIT;
			end
			TSQ_WAIT: begin
				if (cmd_abort)
					nxt_state = TSQ_ABORT;
				else if (arm_now)
					nxt_state = TSQ_SWEEP;
			end
			TSQ_SWEEP: begin
				if (cmd_abort)
					nxt_state = TSQ_ABORT;
				else if (list_end)
					nxt_state = (count_left_ff == COUNT_MIN) ?
						TSQ_IDLE : TSQ_WAIT;
			end
			TSQ_ABORT: begin
				if (abort_cnt_ff == ABORT_CYCLES - 4'h1)
					nxt_state = TSQ_IDLE;
			end
			default: nxt_state = TSQ_IDLE;
		endcase
	end

	// State, abort timer and remaining count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= TSQ_IDLE;
			abort_cnt_ff <= '0;
			count_left_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			abort_cnt_ff <= (state_ff == TSQ_ABORT) ?
				abort_cnt_ff + 4'h1 : '0;
			if (state_ff == TSQ_IDLE && nxt_state == TSQ_WAIT)
				count_left_ff <= count_set_ff;
			else if (state_ff == TSQ_SWEEP && list_end && !cmd_abort)
				count_left_ff <= count_left_ff - CNT_W'(1);
			else if (nxt_state == TSQ_ABORT)
				count_left_ff <= '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			step_begin_ff <= 1'b0;
		else
			step_begin_ff <= state_ff == TSQ_WAIT && arm_now &&
				!cmd_abort;
	end

	// ****************************************************************
	// Settling flag
	// ****************************************************************

	// Change sets, settle clears; set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			settling_ff <= 1'b0;
		else if (func_change)
			settling_ff <= 1'b1;
		else if (settle_done)
			settling_ff <= 1'b0;
	end

	// ****************************************************************
	// Self-test result
	// ****************************************************************

	// Result latched at end of test
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			test_done_ff <= 1'b0;
			test_pass_ff <= 1'b0;
		end else begin
			test_done_ff <= lnk.t_done;
			if (lnk.t_done)
				test_pass_ff <= lnk.t_pass;
		end
	end

	// ****************************************************************
	// Operation condition word
	// ****************************************************************

	// Word built from live state, then registered onto the port
	always_comb begin
		nxt_opcond = RST_OPC;
		nxt_opcond[OPC_SETTLING] = settling_ff;
		nxt_opcond[OPC_SWEEPING] = state_ff == TSQ_SWEEP;
		nxt_opcond[OPC_WAIT_ARM] = state_ff == TSQ_WAIT;
		nxt_opcond[OPC_TESTING] = lnk.t_busy;
		nxt_opcond[OPC_ABORTING] = state_ff == TSQ_ABORT;
		if (master_sel)
			nxt_opcond = RST_OPC;
	end

	// One cycle behind the state it reflects
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			opcond_ff <= RST_OPC;
		else
			opcond_ff <= nxt_opcond;
	end

endmodule // tsq_sequencer

// ==== verification/tsq_checker.sv ====
/* Port assertions for the trigger and status sequencer.
   Assumes it is bound to tsq_sequencer on one clock. */
`timescale 1ns/10ps
module tsq_checker
	import tsq_pkg::*;
#(
	parameter int MS_CYC = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [tsq_pkg::CMD_W-1:0] cmd_code,
	input wire logic func_change,
	input wire logic master_sel,
	input wire logic [tsq_pkg::OPC_W-1:0] opcond_ff,
	input wire logic step_begin_ff,
	input wire logic [tsq_pkg::CNT_W-1:0] count_set_ff,
	input wire logic [tsq_pkg::ARG_W-1:0] delay_set_ff,
	input wire logic [tsq_pkg::ARG_W-1:0] trigger_event_tally_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// Condition word
	// ****
	chk_unused_zero:
	assert property ((opcond_ff & ~16'h032A) == 16'h0000)
		else $error("unused condition bit set");
	chk_master_zero:
	assert property (master_sel && $past(master_sel) |-> opcond_ff == 16'h0000)
		else $error("condition word not zero under master");
	chk_settle_set:
	assert property (func_change && !master_sel |-> ##[1:3] opcond_ff[1])
		else $error("settling bit missing");
	chk_abort_span:
	assert property ($rose(opcond_ff[OPC_ABORTING]) |->
		opcond_ff[OPC_ABORTING] [*4] ##1 !opcond_ff[OPC_ABORTING])
		else $error("abort bit span wrong");
	chk_abort_sweep:
	assert property ($rose(opcond_ff[OPC_ABORTING]) |-> !opcond_ff[OPC_SWEEPING])
		else $error("sweep bit kept over abort");
	chk_step_sweep:
	assert property (step_begin_ff && !master_sel |=>
		opcond_ff[OPC_SWEEPING] && !opcond_ff[OPC_WAIT_ARM])
		else $error("arm wait not left at step");
	chk_test_bit:
	assert property (cmd_valid && cmd_code == CMD_SELF_TEST && !master_sel &&
		opcond_ff == 16'h0000 |-> ##2 opcond_ff[OPC_TESTING])
		else $error("testing bit missing");
	chk_step_pulse:
	assert property (step_begin_ff |=> !step_begin_ff)
		else $error("step pulse too long");
	// ****
	// Settings
	// ****
	chk_count_range:
	assert property (count_set_ff != 16'h0000)
		else $error("trigger count zero");
	chk_delay_range:
	assert property (delay_set_ff <= ARG_MAX)
		else $error("delay above limit");
	chk_delay_clr:
	assert property (cmd_valid && cmd_code == CMD_SET_DELAY |=>
		trigger_event_tally_ff == 17'h00000)
		else $error("tally not cleared by delay");
	chk_tally_clr:
	assert property (cmd_valid && cmd_code == CMD_SET_TALLY |=>
		delay_set_ff == 17'h00000)
		else $error("delay not cleared by tally");
endmodule // tsq_checker

bind tsq_sequencer tsq_checker #(.MS_CYC(MS_CYC)) tsq_checker_inst (.clk,
	.rst, .cmd_valid, .cmd_code, .func_change, .master_sel, .opcond_ff,
	.step_begin_ff, .count_set_ff, .delay_set_ff, .trigger_event_tally_ff);

// ==== verification/tsq_host_model.sv ====
/* Host side: command strobes and test loopback.
   Assumes commands are launched on falling edges. */
`timescale 1ns/10ps
module tsq_host_model
	import tsq_pkg::*;
(
	input wire logic clk,
	input wire logic loop_bad,
	input wire logic [tsq_pkg::TPAT_W-1:0] test_pat_ff,
	output logic cmd_valid,
	output logic [tsq_pkg::CMD_W-1:0] cmd_code,
	output logic [tsq_pkg::ARG_W-1:0] cmd_arg,
	output logic [tsq_pkg::TPAT_W-1:0] test_loop_in
);
	// Loopback, bit 1 flipped on demand to force a failed test
	assign test_loop_in = test_pat_ff ^ {14'h0000, loop_bad, 1'b0};
	// Idle lines show junk, never the last command
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 4'hF;
		cmd_arg = 17'h1FFFF;
	end
	// One-cycle command, then lines inverted
	task send(input logic [CMD_W-1:0] c, input logic [ARG_W-1:0] a);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_arg = a;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_arg = ~a;
	endtask
endmodule // tsq_host_model

// ==== verification/tb.sv ====
/* Self-checking bench of the sequencer.
   Assumes MS_CYC of 4 to keep delays short. */
`timescale 1ns/10ps
module tb;
	import tsq_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [SRC_N-1:0] trig_lines = '0;
	logic func_change = 1'b0;
	logic settle_done = 1'b0;
	logic list_end = 1'b0;
	logic master_sel = 1'b0;
	logic loop_bad = 1'b0;
	logic cmd_valid;
	logic [CMD_W-1:0] cmd_code;
	logic [ARG_W-1:0] cmd_arg;
	logic [TPAT_W-1:0] test_loop_in, test_pat_ff, test_fail_data_ff;
	logic [OPC_W-1:0] opcond_ff;
	logic step_begin_ff, test_done_ff, test_pass_ff;
	logic [CNT_W-1:0] count_set_ff, count_left_ff;
	logic [ARG_W-1:0] delay_set_ff, trigger_event_tally_ff;
	logic [SRC_W-1:0] source_set_ff;
	logic [TSTEP_W-1:0] test_fail_step_ff;
	logic got;
	int err_total = 0;
	int checks_done = 0;

	// Half period of 25 ns gives 20 MHz
	always #25 clk = ~clk;

	tsq_sequencer #(.MS_CYC(4)) tsq_sequencer_inst (.clk, .rst, .cmd_valid,
		.cmd_code, .cmd_arg, .trig_lines, .func_change, .settle_done,
		.list_end, .master_sel, .test_loop_in, .opcond_ff, .step_begin_ff,
		.count_set_ff, .delay_set_ff, .trigger_event_tally_ff, .source_set_ff,
		.count_left_ff, .test_done_ff, .test_pass_ff, .test_pat_ff,
		.test_fail_step_ff, .test_fail_data_ff);
	tsq_host_model tsq_host_model_inst (.clk, .loop_bad, .test_pat_ff,
		.cmd_valid, .cmd_code, .cmd_arg, .test_loop_in);

	// ****
	// Helpers
	// ****
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task cmd(input logic [CMD_W-1:0] c, input int a);
		tsq_host_model_inst.send(c, ARG_W'(a));
	endtask
	// Bounded wait for step (w=0) or test end (w=1)
	task wfor(input int n, input bit w);
		got = 1'b0;
		for (int i = 0; i < n && !got; i++) begin
			@(negedge clk);
			got = w ? (test_done_ff === 1'b1) : (step_begin_ff === 1'b1);
		end
	endtask
	task trig(input int i);
		trig_lines[i] = 1'b1;
		@(negedge clk);
		trig_lines[i] = 1'b0;
		// One idle edge only, so the step pulse that follows is not missed
		@(negedge clk);
	endtask
	task endlist;
		list_end = 1'b1;
		@(negedge clk);
		list_end = 1'b0;
	endtask

	// ****
	// Scenarios
	// ****
	task t_reset;
		chk("count", count_set_ff, 1);
		chk("delay", delay_set_ff, 0);
		chk("tally", trigger_event_tally_ff, 0);
		chk("source", source_set_ff, SRC_IMMEDIATE);
		chk("opcond", opcond_ff, 0);
	endtask
	task t_settings;
		cmd(CMD_SET_COUNT, 0);
		chk("count zero", count_set_ff, 1);
		cmd(CMD_SET_COUNT, 17'h1FFFF);
		chk("count top", count_set_ff, 16'hFFFF);
		cmd(CMD_SET_DELAY, 17'h1FFFF);
		chk("delay top", delay_set_ff, ARG_MAX);
		cmd(CMD_SET_TALLY, 3);
		chk("delay clr", delay_set_ff, 0);
		cmd(CMD_SET_DELAY, 2);
		chk("tally clr", trigger_event_tally_ff, 0);
		// Code 23 is past the last source and must leave 22 in place
		for (int i = 0; i <= SRC_N; i++) begin
			cmd(CMD_SET_SOURCE, i);
			chk("source", source_set_ff, i < SRC_N ? i : SRC_N - 1);
		end
	endtask
	task t_delay;
		cmd(CMD_SET_COUNT, 1);
		cmd(CMD_SET_SOURCE, SRC_BUS);
		cmd(CMD_INITIATE, 0);
		repeat (3) @(negedge clk);
		chk("arm wait", opcond_ff[OPC_WAIT_ARM], 1);
		trig(SRC_BUS);
		wfor(5, 0);
		chk("early step", got, 0);
		wfor(20, 0);
		chk("delayed step", got, 1);
		endlist;
		repeat (3) @(negedge clk);
		chk("idle", opcond_ff, 0);
	endtask
	task t_tally;
		cmd(CMD_SET_TALLY, 3);
		cmd(CMD_SET_SOURCE, SRC_TTL0 + 2);
		cmd(CMD_INITIATE, 0);
		trig(SRC_TTL0 + 2);
		trig(SRC_TTL0 + 2);
		wfor(6, 0);
		chk("tally early", got, 0);
		trig(SRC_TTL0 + 2);
		wfor(6, 0);
		chk("tally step", got, 1);
		endlist;
	endtask
	task t_count;
		cmd(CMD_SET_TALLY, 0);
		cmd(CMD_SET_SOURCE, SRC_IMMEDIATE);
		cmd(CMD_SET_COUNT, 2);
		cmd(CMD_INITIATE, 0);
		wfor(10, 0);
		chk("pass one", got, 1);
		repeat (2) @(negedge clk);
		chk("sweeping", opcond_ff[OPC_SWEEPING], 1);
		endlist;
		chk("count left", count_left_ff, 1);
		wfor(10, 0);
		chk("pass two", got, 1);
		endlist;
		wfor(10, 0);
		chk("no third", got, 0);
		chk("back idle", opcond_ff, 0);
		chk("count spent", count_left_ff, 0);
	endtask
	task t_abort;
		cmd(CMD_SET_COUNT, 1);
		cmd(CMD_SET_SOURCE, SRC_HOLD);
		cmd(CMD_INITIATE, 0);
		wfor(8, 0);
		chk("hold step", got, 0);
		cmd(CMD_TRIG_IMM, 0);
		wfor(6, 0);
		chk("imm step", got, 1);
		cmd(CMD_ABORT, 0);
		@(negedge clk);
		chk("aborting", opcond_ff[OPC_ABORTING], 1);
		chk("sweep off", opcond_ff[OPC_SWEEPING], 0);
		repeat (5) @(negedge clk);
		chk("abort done", opcond_ff, 0);
	endtask
	task t_settle;
		func_change = 1'b1;
		@(negedge clk);
		func_change = 1'b0;
		repeat (3) @(negedge clk);
		chk("settling", opcond_ff[OPC_SETTLING], 1);
		master_sel = 1'b1;
		repeat (2) @(negedge clk);
		chk("master", opcond_ff, 0);
		master_sel = 1'b0;
		settle_done = 1'b1;
		@(negedge clk);
		settle_done = 1'b0;
		repeat (3) @(negedge clk);
		chk("settled", opcond_ff, 0);
	endtask
	task t_test;
		cmd(CMD_SELF_TEST, 0);
		@(negedge clk);
		chk("testing", opcond_ff[OPC_TESTING], 1);
		wfor(100, 1);
		chk("test end", got, 1);
		chk("test pass", test_pass_ff, 1);
		repeat (3) @(negedge clk);
		chk("test off", opcond_ff[OPC_TESTING], 0);
		// First step drives 0001; the flipped loopback reads 0003
		loop_bad = 1'b1;
		cmd(CMD_SELF_TEST, 0);
		wfor(100, 1);
		chk("test fail", test_pass_ff, 0);
		repeat (5) @(negedge clk);
		chk("fail step", test_fail_step_ff, 0);
		chk("fail data", test_fail_data_ff, 16'h0003);
		loop_bad = 1'b0;
	endtask

	task end_sim;
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Scenarios take under 2000 cycles; the watchdog allows ten times that
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim;
	end
	// Reset for 20 cycles, then every scenario in turn
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_reset;
		t_settings;
		t_delay;
		t_tally;
		t_count;
		t_abort;
		t_settle;
		t_test;
		end_sim;
	end
endmodule // tb
